// >>> igf_top.v
// Glitch filter with grouped port-0 mode and change detection, AXI4-Lite
//
// Behaviour
// (R1) Each line picks one of three fixed widths: 90 ns, 5.12 us, 2.56 ms.
// (R2) Enabled filter passes any pulse at least the programmed width.
// (R3) Software programs a width whenever it enables a line's filter.
// (R4) The custom width comes from one 32-bit utility counter.
// (R5) External tick used only when both source and rate are configured.
// (R6) Grouped port 0 reports skewed changes within one width as one change.
// (R7) Grouped change reported only after a further stable width.
// (R8) Lines other than port 0 may use the one shared custom width.
// (R9) Only one custom width value exists on the whole device.
// (R10) One rise and one fall before a read is not an overrun.
// (R11) Two rises or two falls before a read raise the overrun flag.
// (R12) Buffered change detection claims the parallel input path exclusively.
// (R13) Unbuffered operations neither reserve nor use the parallel path.
// (R14) Output changes only after input holds new level; glitches restart.
// (R15) Overrun flag stays until the sample is read or cleared.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "igf_regs.vh"
module igf_top (
    input  wire        aclk,           // 125 MHz clock
    input  wire        aresetn,        // Synchronous reset, active low
    input  wire [7:0]  line_in,        // Raw digital lines, async
    input  wire        ext_tick_in,    // External filter timebase, async
    input  wire [7:0]  s_axi_awaddr,   // Write address
    input  wire        s_axi_awvalid,  // Write address valid
    output reg         s_axi_awready,  // Write address ready
    input  wire [31:0] s_axi_wdata,    // Write data
    input  wire [3:0]  s_axi_wstrb,    // Write strobes
    input  wire        s_axi_wvalid,   // Write data valid
    output reg         s_axi_wready,   // Write data ready
    output reg  [1:0]  s_axi_bresp,    // Write response
    output reg         s_axi_bvalid,   // Write response valid
    input  wire        s_axi_bready,   // Write response ready
    input  wire [7:0]  s_axi_araddr,   // Read address
    input  wire        s_axi_arvalid,  // Read address valid
    output reg         s_axi_arready,  // Read address ready
    output reg  [31:0] s_axi_rdata,    // Read data
    output reg  [1:0]  s_axi_rresp,    // Read response
    output reg         s_axi_rvalid,   // Read data valid
    input  wire        s_axi_rready,   // Read data ready
    output reg  [7:0]  filtered_out,   // Filtered line levels
    output reg         par_path_busy,  // Parallel input path claimed
    output reg         change_event    // One-cycle change report
);
    parameter [31:0] W2MS_TICKS = `IGF_CYC(`IGF_W2MS_NS);
    localparam [31:0] W90_TICKS  = `IGF_CYC(`IGF_W90_NS);
    localparam [31:0] W5US_TICKS = `IGF_CYC(`IGF_W5US_NS);

    // Software-visible configuration
    reg [7:0]  glitch_filter_on;
    reg [15:0] min_pass_width;
    reg [31:0] custom_width;
    reg        filter_tick_source;
    reg        filter_tick_rate;
    reg        group_mode;
    reg        buf_req;
    reg        unbuf_req;
    reg        ovr_clr;
    reg [7:0]  sample_hold;

    // Two-flop synchronisers for pins
    reg [7:0] line_s1;
    reg [7:0] line_s2;
    reg       ext_s1;
    reg       ext_s2;
    reg       ext_s3;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_s1 <= 8'h00;
            line_s2 <= 8'h00;
            ext_s1  <= 1'b0;
            ext_s2  <= 1'b0;
            ext_s3  <= 1'b0;
        end
        else
        begin
            line_s1 <= line_in;
            line_s2 <= line_s1;
            ext_s1  <= ext_tick_in;
            ext_s2  <= ext_s1;
            ext_s3  <= ext_s2;
        end
    end

    // Tick from external edge only if both source and rate are set
    wire use_ext = filter_tick_source & filter_tick_rate;   // [R5]
    wire tick    = use_ext ? (ext_s2 & ~ext_s3) : 1'b1;     // [R5]

    // Width per line; custom widths share the single utility count
    wire [31:0] limit [0:7];
    wire [7:0]  filt;
    genvar g;
    generate
        for (g = 0; g < `IGF_LINES; g = g + 1)
        begin : g_line
            wire [1:0] sel = min_pass_width[2*g+1:2*g];
            // Port 0 has no custom width, so code 3 falls back to 2.56 ms
            wire cust_ok = (g >= `IGF_PORT0_LINES);         // [R8]
            assign limit[g] =
                (sel == `IGF_SEL_90NS)  ? W90_TICKS :       // [R1]
                (sel == `IGF_SEL_5US)   ? W5US_TICKS :      // [R1]
                (sel == `IGF_SEL_CUSTOM && cust_ok) ?
                                          custom_width :    // [R4] [R9]
                                          W2MS_TICKS;       // [R1]
            igf_line_filter u_filt (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .raw_in   (line_s2[g]),
                .tick     (tick),
                .enable   (glitch_filter_on[g]),
                .limit    (limit[g]),
                .filt_out (filt[g])
            );
        end
    endgenerate

    // Grouped port 0: wait a further full width of stability
    reg [31:0] grp_cnt;
    reg        grp_wait;
    reg [7:0]  filt_d;
    wire [7:0] diff = filt ^ filt_d;
    wire [31:0] grp_limit = limit[0];
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            grp_cnt  <= 32'h0000_0000;
            grp_wait <= 1'b0;
        end
        else if (!group_mode)
        begin
            grp_wait <= 1'b0;
            grp_cnt  <= 32'h0000_0000;
        end
        else if (diff[3:0] != 4'h0)
        begin
            // A new change in the window restarts the stability wait
            grp_wait <= 1'b1;                               // [R6]
            grp_cnt  <= 32'h0000_0000;                      // [R7]
        end
        else if (grp_wait && tick)
        begin
            if (grp_cnt + 32'h0000_0001 >= grp_limit)
            begin
                grp_wait <= 1'b0;                           // [R7]
                grp_cnt  <= 32'h0000_0000;
            end
            else
                grp_cnt <= grp_cnt + 32'h0000_0001;
        end
    end
    wire grp_done = group_mode & grp_wait & tick &
                    (grp_cnt + 32'h0000_0001 >= grp_limit) &
                    (diff[3:0] == 4'h0);

    // Parallel path ownership: buffered claims it, unbuffered never does
    wire armed = buf_req;                                   // [R12] [R13]
    wire [7:0] rise_v = diff & filt;
    wire [7:0] fall_v = diff & ~filt;
    wire [7:0] ovr;
    wire       rd_sample;
    generate
        for (g = 0; g < `IGF_LINES; g = g + 1)
        begin : g_edge
            igf_edge_track u_trk (
                .aclk    (aclk),
                .aresetn (aresetn),
                .rise    (rise_v[g]),
                .fall    (fall_v[g]),
                .arm     (armed),
                .clr     (rd_sample | ovr_clr),             // [R15]
                .overrun (ovr[g])
            );
        end
    endgenerate

    // Outputs, change report and captured sample
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            filt_d        <= 8'h00;
            filtered_out  <= 8'h00;
            par_path_busy <= 1'b0;
            change_event  <= 1'b0;
            sample_hold   <= 8'h00;
        end
        else
        begin
            filt_d        <= filt;
            par_path_busy <= armed;                         // [R12]
            if (group_mode)
                filtered_out <= {filt[7:4],
                                 (grp_wait | (diff[3:0] != 4'h0)) ?
                                 filtered_out[3:0] : filt[3:0]}; // [R7]
            else
                filtered_out <= filt;
            // Grouped lines give one event once they settle
            change_event <= armed &
                ((group_mode ? grp_done : (diff[3:0] != 4'h0)) |
                 (diff[7:4] != 4'h0));                      // [R6]
            if (armed && diff != 8'h00)
                sample_hold <= filt;
        end
    end

    // AXI4-Lite write: take address and data in either order
    reg       aw_held;
    reg       w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `IGF_RESP_OKAY;
            glitch_filter_on   <= `IGF_RST_ENABLE;
            min_pass_width     <= `IGF_RST_SEL;
            custom_width       <= `IGF_RST_CUSTOM;
            filter_tick_source <= 1'b0;
            filter_tick_rate   <= 1'b0;
            group_mode <= 1'b0;
            buf_req    <= 1'b0;
            unbuf_req  <= 1'b0;
            ovr_clr    <= 1'b0;
        end
        else
        begin
            ovr_clr       <= 1'b0;
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `IGF_RESP_OKAY;
                case (aw_addr)
                    `IGF_REG_ENABLE:
                        if (w_strb[0]) glitch_filter_on <= w_data[7:0];
                    `IGF_REG_SEL_LO:
                    begin
                        if (w_strb[0]) min_pass_width[7:0]  <= w_data[7:0];
                        if (w_strb[1]) min_pass_width[15:8] <= w_data[15:8];
                    end
                    `IGF_REG_CUSTOM:
                    begin
                        if (w_strb[0]) custom_width[7:0]   <= w_data[7:0];
                        if (w_strb[1]) custom_width[15:8]  <= w_data[15:8];
                        if (w_strb[2]) custom_width[23:16] <= w_data[23:16];
                        if (w_strb[3]) custom_width[31:24] <= w_data[31:24];
                    end
                    `IGF_REG_TICKCFG:
                        if (w_strb[0])
                        begin
                            filter_tick_source <= w_data[`IGF_TICK_SRC_BIT];
                            filter_tick_rate   <= w_data[`IGF_TICK_RATE_BIT];
                        end
                    `IGF_REG_CTRL:
                        if (w_strb[0])
                        begin
                            group_mode <= w_data[`IGF_CTRL_GROUP_BIT];
                            // Buffered request wins over unbuffered
                            buf_req   <= w_data[`IGF_CTRL_BUF_BIT];
                            unbuf_req <= w_data[`IGF_CTRL_UNBUF_BIT] &
                                         ~w_data[`IGF_CTRL_BUF_BIT];
                        end
                    `IGF_REG_OVERRUN:
                        ovr_clr <= w_strb[0];
                    `IGF_REG_STATE, `IGF_REG_SAMPLE, `IGF_REG_STATUS:
                        s_axi_bresp <= `IGF_RESP_OKAY;
                    default:
                        s_axi_bresp <= `IGF_RESP_SLVERR;
                endcase
            end
        end
    end

    // AXI4-Lite read: reading the sample clears overrun flags
    reg [31:0] next_rdata;
    reg [1:0]  next_rresp;
    reg        rd_pend;
    assign rd_sample = s_axi_arready && s_axi_araddr == `IGF_REG_SAMPLE;
    always @*
    begin
        next_rresp = `IGF_RESP_OKAY;
        case (s_axi_araddr)
            `IGF_REG_ENABLE:  next_rdata = {24'h00_0000, glitch_filter_on};
            `IGF_REG_SEL_LO:  next_rdata = {16'h0000, min_pass_width};
            `IGF_REG_CUSTOM:  next_rdata = custom_width;
            `IGF_REG_TICKCFG: next_rdata = {30'h0000_0000,
                                            filter_tick_rate,
                                            filter_tick_source};
            `IGF_REG_CTRL:    next_rdata = {29'h0000_0000, unbuf_req,
                                            buf_req, group_mode};
            `IGF_REG_STATE:   next_rdata = {24'h00_0000, filt};
            `IGF_REG_SAMPLE:  next_rdata = {24'h00_0000, sample_hold};
            `IGF_REG_OVERRUN: next_rdata = {24'h00_0000, ovr};
            `IGF_REG_STATUS:  next_rdata = {30'h0000_0000, use_ext,
                                            armed};
            default:
            begin
                next_rdata = 32'h0000_0000;
                next_rresp = `IGF_RESP_SLVERR;
            end
        endcase
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `IGF_RESP_OKAY;
            rd_pend       <= 1'b0;
        end
        else
        begin
            // One read outstanding; ready pulses only when idle
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~rd_pend;
            if (s_axi_arready)
            begin
                rd_pend      <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rresp;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                rd_pend      <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> igf_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef IGF_REGS_VH
`define IGF_REGS_VH

// Line count and geometry
`define IGF_LINES           8
`define IGF_PORT0_LINES     4

// Register byte offsets
`define IGF_REG_ENABLE      8'h00
`define IGF_REG_SEL_LO      8'h04
`define IGF_REG_CUSTOM      8'h08
`define IGF_REG_TICKCFG     8'h0C
`define IGF_REG_CTRL        8'h10
`define IGF_REG_STATE       8'h14
`define IGF_REG_SAMPLE      8'h18
`define IGF_REG_OVERRUN     8'h1C
`define IGF_REG_STATUS      8'h20

// Width select codes, two bits per line
`define IGF_SEL_90NS        2'h0
`define IGF_SEL_5US         2'h1
`define IGF_SEL_2MS         2'h2
`define IGF_SEL_CUSTOM      2'h3

// Fixed widths in ns and their cycle counts at 8 ns per cycle
`define IGF_CLK_NS          8
`define IGF_W90_NS          90
`define IGF_W5US_NS         5120
`define IGF_W2MS_NS         2560000
`define IGF_CYC(ns)         (((ns) + `IGF_CLK_NS - 1) / `IGF_CLK_NS)

// Tick config fields
`define IGF_TICK_SRC_BIT    0
`define IGF_TICK_RATE_BIT   1

// Control fields
`define IGF_CTRL_GROUP_BIT  0
`define IGF_CTRL_BUF_BIT    1
`define IGF_CTRL_UNBUF_BIT  2

// Reset values
`define IGF_RST_ENABLE      8'h00
`define IGF_RST_SEL         16'h0000
`define IGF_RST_CUSTOM      32'h0000_0010

// Write and read responses; SLVERR answers unmapped addresses
`define IGF_RESP_OKAY       2'b00
`define IGF_RESP_SLVERR     2'b10

`endif

// >>> igf_line_filter.v
// One glitch-filter stage: output follows input after a stable hold
`timescale 1ns/1ps
`default_nettype none
module igf_line_filter (
    input  wire        aclk,     // System clock
    input  wire        aresetn,  // Synchronous reset, active low
    input  wire        raw_in,   // Synchronised raw level
    input  wire        tick,     // Filter timebase tick
    input  wire        enable,   // Filter on
    input  wire [31:0] limit,    // Required stable ticks
    output reg         filt_out  // Filtered level
);
    reg [31:0] hold_cnt;

    // Count ticks while input differs; any return restarts the count
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_cnt <= 32'h0000_0000;
            filt_out <= 1'b0;
        end
        else if (!enable)
        begin
            hold_cnt <= 32'h0000_0000;
            filt_out <= raw_in;
        end
        else if (raw_in == filt_out)
            hold_cnt <= 32'h0000_0000;                      // [R14]
        else if (tick)
        begin
            if (hold_cnt + 32'h0000_0001 >= limit)
            begin
                filt_out <= raw_in;                         // [R2] [R14]
                hold_cnt <= 32'h0000_0000;
            end
            else
                hold_cnt <= hold_cnt + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// >>> igf_edge_track.v
// Per-line edge tracker: flags a second rise or a second fall since the last read or clear
`timescale 1ns/1ps
`default_nettype none
module igf_edge_track (
    input  wire aclk,      // System clock
    input  wire aresetn,   // Synchronous reset, active low
    input  wire rise,      // Rising edge seen
    input  wire fall,      // Falling edge seen
    input  wire arm,       // Buffered detection running
    input  wire clr,       // Sample read or explicit clear
    output reg  overrun    // Sticky overrun flag
);
    reg seen_rise;
    reg seen_fall;

    // One rise plus one fall is fine; a second edge of the same kind is not
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seen_rise <= 1'b0;
            seen_fall <= 1'b0;
            overrun   <= 1'b0;
        end
        else
        begin
            seen_rise <= arm & rise | (seen_rise & ~clr);   // [R10]
            seen_fall <= arm & fall | (seen_fall & ~clr);   // [R10]
            // Clear beats set; an edge in the read cycle only sets seen_rise or seen_fall
            if (arm & ((rise & seen_rise & ~clr) |
                       (fall & seen_fall & ~clr)))
                overrun <= 1'b1;                            // [R11]
            else if (clr)
                overrun <= 1'b0;                            // [R15]
        end
    end
endmodule
`default_nettype wire

// >>> igf_checker.sv
// Port-level assertions for the glitch filter block
`timescale 1ns/1ps
`default_nettype none
module igf_checker (
    input wire logic       aclk,          // Clock
    input wire logic       aresetn,       // Sync reset, active low
    input wire logic [7:0] line_in,       // Raw lines
    input wire logic       s_axi_awvalid, // AW valid
    input wire logic       s_axi_awready, // AW ready
    input wire logic       s_axi_wready,  // W ready
    input wire logic       s_axi_bvalid,  // B valid
    input wire logic       s_axi_bready,  // B ready
    input wire logic       s_axi_arready, // AR ready
    input wire logic       s_axi_rvalid,  // R valid
    input wire logic       s_axi_rready,  // R ready
    input wire logic [7:0] filtered_out,  // Filtered levels
    input wire logic       par_path_busy, // Path claimed
    input wire logic       change_event   // Change pulse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [4:0] st0;
    logic       prev0;
    // Stable age of raw line 0; saturates so a long hold never wraps
    always @(posedge aclk)
    begin
        prev0 <= line_in[0];
        if (!aresetn || line_in[0] != prev0)
            st0 <= 5'h00;
        else if (st0 != 5'h1f)
            st0 <= st0 + 5'h01;
    end
    chk_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid))
        else $error("awready without awvalid");
    chk_aw_once: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    chk_w_once: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    chk_b_drop: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stayed after handshake");
    chk_r_drop: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stayed after handshake");
    chk_ar_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("no read data after arready");
    chk_event_armed: assert property (
        change_event |-> par_path_busy || $past(par_path_busy))
        else $error("change event while not armed");
    chk_hold_width: assert property (
        filtered_out[0] != $past(filtered_out[0]) |-> st0 >= 5'h0c)
        else $error("line 0 output moved before a full width");
endmodule
bind igf_top igf_checker chk (.*);
`default_nettype wire

// >>> igf_sig_src.sv
// Far-side source of raw lines and external filter timebase
`timescale 1ns/1ps
`default_nettype none
module igf_sig_src (
    input  wire logic       aclk,       // Clock
    input  wire logic       tick_on,    // Run the external timebase
    output var  logic [7:0] line_in,    // Raw lines
    output var  logic       ext_tick_in // External tick
);
    initial line_in = 8'h00;
    initial ext_tick_in = 1'h0;
    // Stands still when off, so stray ticks cannot hide a wrong source
    always @(posedge aclk)
        ext_tick_in <= tick_on ? ~ext_tick_in : 1'h0;
    // Level change on one line, launched just after an edge
    task set(input int i, input logic v);
        line_in[i] <= v;
    endtask
endmodule
`default_nettype wire

// >>> input_glitch_filter_change_detect_tb.sv
// Self-checking bench for the glitch filter block
`timescale 1ns/1ps
`default_nettype none
`include "igf_regs.vh"
module input_glitch_filter_change_detect_tb;
    localparam int          W2MS = 50;
    localparam logic [31:0] ALL  = 32'hffff_ffff;
    localparam logic [1:0]  OK   = `IGF_RESP_OKAY;
    localparam logic [7:0]  OVR  = `IGF_REG_OVERRUN;
    logic        aclk          = 1'h0;
    logic        aresetn       = 1'h0;
    logic        tick_on       = 1'h0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'h0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hf;
    logic        s_axi_wvalid  = 1'h0;
    logic        s_axi_bready  = 1'h0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_rready  = 1'h0;
    wire  [7:0]  line_in;
    wire         ext_tick_in, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid, par_path_busy, change_event;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [7:0]  filtered_out;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          n_ev        = 0;
    igf_top #(.W2MS_TICKS(32'(W2MS))) DUT (
        .aclk, .aresetn, .line_in, .ext_tick_in, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .filtered_out, .par_path_busy, .change_event
    );
    igf_sig_src src (.aclk, .tick_on, .line_in, .ext_tick_in);
    initial
        forever #4 aclk = ~aclk;
    // Count change pulses so merges show up
    always @(posedge aclk)
        if (change_event === 1'h1) n_ev <= n_ev + 1;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Address and data go out together; each drops once it is taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
            input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata & m, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // One pulse: level at its end, then back low
    task pw(input int i, input int hi, input logic e);
        src.set(i, 1'h1);
        cyc(hi);
        chk(32'(filtered_out[i]), 32'(e));
        src.set(i, 1'h0);
        cyc(hi + 40);
        chk(32'(filtered_out[i]), 32'h0);
    endtask
    task t_regs;
        rd(`IGF_REG_ENABLE, 32'h0, ALL, OK);
        rd(`IGF_REG_SEL_LO, 32'h0, ALL, OK);
        rd(`IGF_REG_CUSTOM, 32'h10, ALL, OK);
        rd(8'h40, 32'h0, ALL, `IGF_RESP_SLVERR);
        wr(8'h40, ALL, `IGF_RESP_SLVERR);
        wr(`IGF_REG_CUSTOM, 32'h14, OK);
        rd(`IGF_REG_CUSTOM, 32'h14, ALL, OK);
        wr(`IGF_REG_STATE, 32'hff, OK);
        rd(`IGF_REG_STATE, 32'h0, ALL, OK);
        // All on; 4 custom, 5 at 5.12 us, 6 and port-0 line 3 at 2.56 ms
        wr(`IGF_REG_ENABLE, 32'hff, OK);
        wr(`IGF_REG_SEL_LO, 32'h27c0, OK);
        $display("test regs done");
    endtask
    task t_width;
        int idx[5] = '{0, 4, 5, 6, 3};
        int lim[5] = '{`IGF_CYC(`IGF_W90_NS), 20,
                       `IGF_CYC(`IGF_W5US_NS), W2MS, W2MS};
        for (int k = 0; k < 5; k++)
        begin
            pw(idx[k], lim[k] / 2, 1'h0);
            pw(idx[k], lim[k] + 6, 1'h1);
        end
        $display("test widths done");
    endtask
    task t_overrun;
        int e0;
        wr(`IGF_REG_CTRL, 32'h2, OK);
        cyc(2);
        chk(32'(par_path_busy), 32'h1);
        e0 = n_ev;
        pw(4, 26, 1'h1);
        chk(32'(n_ev - e0), 32'h2);
        rd(OVR, 32'h0, ALL, OK);
        rd(`IGF_REG_SAMPLE, 32'h0, 32'hff, OK);
        repeat (2) pw(4, 26, 1'h1);
        rd(OVR, 32'h10, 32'hff, OK);
        rd(OVR, 32'h10, 32'hff, OK);
        rd(`IGF_REG_SAMPLE, 32'h0, 32'hff, OK);
        rd(OVR, 32'h0, 32'hff, OK);
        repeat (2) pw(4, 26, 1'h1);
        wr(OVR, 32'h1, OK);
        rd(OVR, 32'h0, 32'hff, OK);
        wr(`IGF_REG_CTRL, 32'h4, OK);
        cyc(2);
        chk(32'(par_path_busy), 32'h0);
        wr(`IGF_REG_CTRL, 32'h6, OK);
        rd(`IGF_REG_CTRL, 32'h2, 32'h6, OK);
        $display("test overrun done");
    endtask
    // Lines 0 and 1 move 3 cycles apart, inside one width
    task t_group;
        int e0;
        wr(`IGF_REG_CTRL, 32'h3, OK);
        e0 = n_ev;
        src.set(0, 1'h1);
        cyc(3);
        src.set(1, 1'h1);
        cyc(16);
        chk(32'(filtered_out[1:0]), 32'h0);
        cyc(30);
        chk(32'(filtered_out[1:0]), 32'h3);
        chk(32'(n_ev - e0), 32'h1);
        src.set(0, 1'h0);
        src.set(1, 1'h0);
        cyc(60);
        $display("test group done");
    endtask
    // Source or rate alone keeps the internal tick
    task t_ext;
        wr(`IGF_REG_TICKCFG, 32'h1, OK);
        rd(`IGF_REG_STATUS, 32'h0, 32'h2, OK);
        wr(`IGF_REG_TICKCFG, 32'h2, OK);
        rd(`IGF_REG_STATUS, 32'h0, 32'h2, OK);
        tick_on <= 1'h1;
        wr(`IGF_REG_TICKCFG, 32'h3, OK);
        rd(`IGF_REG_STATUS, 32'h2, 32'h2, OK);
        pw(7, 18, 1'h0);
        pw(7, 40, 1'h1);
        wr(`IGF_REG_TICKCFG, 32'h0, OK);
        tick_on <= 1'h0;
        $display("test timebase done");
    endtask
    initial
    begin
        #200000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        cyc(2);
        aresetn <= 1'h1;
        t_regs();
        t_width();
        t_overrun();
        t_group();
        t_ext();
        stop_test();
    end
endmodule
`default_nettype wire
